// >>> core/spi_xchg_pkg.sv
// Summary of operation
// - A transfer drives exactly eight SCK pulses, moving one bit out on MOSI and one in on MISO per pulse.
// - Every transfer is full duplex, so a byte is always sent and a byte is always captured together.
// - In master mode MOSI and SCK are driven outputs and MISO is only read.
// - A low level on the slave-select pin, while it is an input, clears master enable and later transfers return zero.
// - While slave-select is an input, initialisation turns on its pull-up.
// - SCK is the system clock divided by 2, 4, 8, 16, 32, 64 or 128.
// - Clock polarity selects SCK idle low (rising leading edge) or idle high (falling leading edge).
// - Bit order selects MSB first (default) or LSB first for both directions.
// - MISO is sampled on the leading SCK edge by default or on the trailing edge as the option.
// - All option bits zero give the defaults, and each option has its own bit.
// - At completion the byte shifted in during that transfer is presented.
// - An optional wait of 0 to 255 microseconds after the eighth pulse holds off completion.
package spi_xchg_pkg;
    // ----------------------------------------
    // Option bit positions
    // ----------------------------------------
    localparam int OPT_IDLE_HIGH_BIT = 0;
    localparam int OPT_LSB_FIRST_BIT = 1;
    localparam int OPT_TRAILING_BIT  = 2;
    localparam logic [2:0] OPT_RESET = 3'h0;
    // ----------------------------------------
    // Divider codes: ratio = 2 << code
    // ----------------------------------------
    localparam logic [2:0] DIV_CODE_RESET = 3'h0;
    localparam logic [2:0] DIV_CODE_MAX   = 3'h6;
    localparam int BITS_PER_XFER = 8;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ      = 100;
    localparam int US_CYCLES    = CLK_MHZ;
    localparam int WAIT_US_MAX  = 255;
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_WAIT, ST_DONE} xfer_state_e;
endpackage

// >>> core/sck_divider.sv
`timescale 1ns/1ps
module sck_divider
    import spi_xchg_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Control
    input  wire logic       run,
    input  wire logic [2:0] div_code,
    // Half-period tick
    output logic            half_tick
);
    logic [6:0] cnt_r;
    logic [6:0] half_len;

    // Half period = ratio/2 = 1 << code system cycles
    always_comb begin
        half_len = 7'(7'h01 << ((div_code > DIV_CODE_MAX) ? DIV_CODE_MAX : div_code));
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 7'h00;
        end else if (!run || half_tick) begin
            cnt_r <= 7'h00;
        end else begin
            cnt_r <= cnt_r + 7'h01;
        end
    end

    assign half_tick = run && (cnt_r == half_len - 7'h01);
endmodule

// >>> core/spi_byte_master.sv
`timescale 1ns/1ps
module spi_byte_master
    import spi_xchg_pkg::*;
#(
    parameter int CYCLES_PER_US = US_CYCLES
)(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Configuration
    input  wire logic       init_pulse,
    input  wire logic [2:0] div_code,
    input  wire logic [2:0] options,
    input  wire logic       ss_is_output,
    // Transfer request
    input  wire logic       start,
    input  wire logic [7:0] tx_byte,
    input  wire logic [7:0] wait_us,
    // Transfer result
    output logic [7:0]      rx_byte,
    output logic            done,
    output logic            busy,
    output logic            master_enable_bit,
    // Pins
    output logic            sck_o,
    output logic            sck_oe,
    output logic            mosi_o,
    output logic            mosi_oe,
    output logic            ss_pullup_en,
    input  wire logic       ss_i,
    input  wire logic       miso_i
);
    // ----------------------------------------
    // Configuration latched at init, and transfer state
    // ----------------------------------------
    logic [2:0]  div_r;
    logic [2:0]  opt_r;
    xfer_state_e state_r;
    logic [7:0]  sh_r;
    logic [7:0]  in_r;
    logic [3:0]  edge_cnt_r;
    logic [7:0]  us_left_r;
    logic [$clog2(CYCLES_PER_US+1)-1:0] us_cnt_r;
    logic        half_tick;
    logic        leading;
    logic        sample_now;
    logic        miso_bit;

    // ----------------------------------------
    // Bit-order helpers
    // ----------------------------------------
    // Bit that goes out next in the chosen order
    function automatic logic first_bit(logic [7:0] b, logic lsb_first);
        return lsb_first ? b[0] : b[7];
    endfunction

    // Drops the bit just sent, zero fills the far end
    function automatic logic [7:0] shift_out(logic [7:0] b, logic lsb_first);
        return lsb_first ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
    endfunction

    sck_divider u_div (
        .clk       (clk),
        .nrst      (nrst),
        .run       (state_r == ST_SHIFT),
        .div_code  (div_r),
        .half_tick (half_tick)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= DIV_CODE_RESET;
            opt_r <= OPT_RESET;
        end else if (init_pulse && !busy) begin
            div_r <= div_code;
            opt_r <= options;
        end
    end

    // Slave-select low as input knocks master mode out until next init
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            master_enable_bit <= 1'b0;
        end else if (!ss_is_output && !ss_i) begin
            master_enable_bit <= 1'b0;
        end else if (init_pulse) begin
            master_enable_bit <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ss_pullup_en <= 1'b0;
            sck_oe       <= 1'b0;
            mosi_oe      <= 1'b0;
        end else if (init_pulse) begin
            ss_pullup_en <= !ss_is_output;
            sck_oe       <= 1'b1;
            mosi_oe      <= 1'b1;
        end
    end

    // ----------------------------------------
    // Shift engine
    // ----------------------------------------
    // Even edge count means the next edge is a leading one
    assign leading    = !edge_cnt_r[0];
    assign sample_now = half_tick && (leading != opt_r[OPT_TRAILING_BIT]);
    assign miso_bit   = miso_i;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r    <= ST_IDLE;
            edge_cnt_r <= 4'h0;
            sh_r       <= 8'h00;
            in_r       <= 8'h00;
            us_left_r  <= 8'h00;
            us_cnt_r   <= '0;
            rx_byte    <= 8'h00;
            done       <= 1'b0;
            busy       <= 1'b0;
            sck_o      <= 1'b0;
            mosi_o     <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    // New polarity shows at once, so no stray edge after init
                    sck_o <= init_pulse ? options[OPT_IDLE_HIGH_BIT]
                                        : opt_r[OPT_IDLE_HIGH_BIT];
                    if (start && !master_enable_bit) begin
                        rx_byte <= 8'h00;
                        done    <= 1'b1;
                    end else if (start) begin
                        busy       <= 1'b1;
                        edge_cnt_r <= 4'h0;
                        us_left_r  <= wait_us;
                        // First bit set up before the leading edge
                        mosi_o <= first_bit(tx_byte, opt_r[OPT_LSB_FIRST_BIT]);
                        // Trailing mode puts every bit out on a leading edge,
                        // so nothing is consumed here
                        if (opt_r[OPT_TRAILING_BIT]) begin
                            sh_r <= tx_byte;
                        end else begin
                            sh_r <= shift_out(tx_byte, opt_r[OPT_LSB_FIRST_BIT]);
                        end
                        state_r <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (!master_enable_bit) begin
                        state_r <= ST_IDLE;
                        sck_o   <= opt_r[OPT_IDLE_HIGH_BIT];
                        busy    <= 1'b0;
                        rx_byte <= 8'h00;
                        done    <= 1'b1;
                    end else if (half_tick) begin
                        sck_o      <= !sck_o;
                        edge_cnt_r <= edge_cnt_r + 4'h1;
                        if (sample_now) begin
                            in_r <= opt_r[OPT_LSB_FIRST_BIT] ? {miso_bit, in_r[7:1]}
                                                              : {in_r[6:0], miso_bit};
                        end
                        // Next bit changes on the edge opposite the sampling one
                        if (!sample_now && edge_cnt_r != 4'(2*BITS_PER_XFER-1)) begin
                            mosi_o <= first_bit(sh_r, opt_r[OPT_LSB_FIRST_BIT]);
                            sh_r   <= shift_out(sh_r, opt_r[OPT_LSB_FIRST_BIT]);
                        end
                        if (edge_cnt_r == 4'(2*BITS_PER_XFER-1)) begin
                            state_r  <= ST_WAIT;
                            us_cnt_r <= '0;
                        end
                    end
                end
                ST_WAIT: begin
                    if (us_left_r == 8'h00) begin
                        state_r <= ST_DONE;
                    end else if (us_cnt_r == CYCLES_PER_US - 1) begin
                        us_cnt_r  <= '0;
                        us_left_r <= us_left_r - 8'h01;
                    end else begin
                        us_cnt_r <= us_cnt_r + 1'b1;
                    end
                end
                ST_DONE: begin
                    rx_byte <= in_r;
                    done    <= 1'b1;
                    busy    <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                    busy    <= 1'b0;
                end
            endcase
        end
    end
endmodule

// >>> dv/spi_xchg_monitor.sv
`timescale 1ns/1ps
module spi_xchg_monitor (
    // Watched ports
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       init_pulse,
    input wire logic       ss_is_output,
    input wire logic       ss_i,
    input wire logic       start,
    input wire logic [7:0] rx_byte,
    input wire logic       done,
    input wire logic       busy,
    input wire logic       master_enable_bit,
    input wire logic       sck_o
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic       sck_q;
    logic [4:0] edges_r;
    wire  [4:0] edges_now = edges_r + 5'(sck_o != sck_q);
    // Toggle count restarts at each accepted start
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sck_q   <= 1'b0;
            edges_r <= 5'h00;
        end else begin
            sck_q   <= sck_o;
            edges_r <= (start && !busy) ? 5'h00 : edges_now;
        end
    end
    AST_EIGHT: assert property (done && master_enable_bit |-> edges_now == 5'h10)
        else $error("sck toggle count wrong");
    AST_DONE_PULSE: assert property (done |=> !done)
        else $error("done too long");
    AST_BUSY_ENDS: assert property (done |-> !busy)
        else $error("busy with done");
    AST_BUSY_RISES: assert property (start && !busy && !done && master_enable_bit
        && (ss_is_output || ss_i) |=> busy) else $error("start not taken");
    AST_OFF_ZERO: assert property (start && !busy && !done && !master_enable_bit
        |-> ##[1:2] (done && rx_byte == 8'h00)) else $error("disabled result wrong");
    AST_SS_DROP: assert property (!ss_is_output && !ss_i |=> !master_enable_bit)
        else $error("master not dropped");
    AST_RX_HOLD: assert property ($changed(rx_byte) |-> done)
        else $error("rx changed without done");
    AST_SCK_STILL: assert property (!busy && !start && !init_pulse |=> $stable(sck_o))
        else $error("sck moved while idle");
endmodule
bind spi_byte_master spi_xchg_monitor mon (.*);

// >>> dv/spi_slave_model.sv
`timescale 1ns/1ps
module spi_slave_model (
    // Pins
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    // Framing and data
    input  wire logic       sel,
    input  wire logic [2:0] opt,
    input  wire logic [7:0] data,
    output logic [7:0]      got
);
    int idx;
    function automatic logic pick(int i);
        return opt[1] ? data[i] : data[7 - i];
    endfunction
    initial miso = 1'b0;
    always @(posedge sel) begin
        idx = opt[2] ? 0 : 1;
        if (!opt[2]) miso = pick(0);
    end
    // No pull on this line, so a released value never stays put
    always @(negedge sel) miso = ~miso;
    always @(sck) if (sel) begin
        if ((sck != opt[0]) == opt[2]) begin
            miso = idx < 8 ? pick(idx) : ~miso;
            idx++;
        end else got = {got[6:0], mosi};
    end
endmodule

// >>> dv/test_spi_byte_master.sv
`timescale 1ns/1ps
module test_spi_byte_master;
    import spi_xchg_pkg::*;
    localparam int CPU = 2;
    logic       clk, nrst, init_pulse, ss_is_output, start, ss_i, done, busy, sck_o, sck_oe;
    logic       master_enable_bit, mosi_o, mosi_oe, ss_pullup_en, miso_i;
    logic [2:0] div_code, options;
    logic [7:0] tx_byte, wait_us, rx_byte, slv_tx, slv_rx;
    int         num_errors = 0, tests_run = 0;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
    spi_byte_master #(.CYCLES_PER_US(CPU)) uut (.*);
    spi_slave_model slv (.sck(sck_o), .mosi(mosi_o), .miso(miso_i), .sel(busy),
        .opt(options), .data(slv_tx), .got(slv_rx));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200_000;
        num_errors++;
        summarize();
    end
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic step(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic init(logic [2:0] d, o, logic so);
        {div_code, options, ss_is_output, init_pulse} = {d, o, so, 1'b1};
        step();
        init_pulse = 0;
        step();
        `CHK(sck_oe & mosi_oe & master_enable_bit, 1'b1)
        `CHK(ss_pullup_en, !so)
        `CHK(sck_o, o[0])
    endtask
    // Poke raises start mid-transfer; it must be ignored
    task automatic xfer(logic [7:0] tx, sx, w, logic poke);
        int         lat = 0;
        logic [7:0] e;
        e = {<<{tx}};
        {slv_tx, tx_byte, wait_us, start} = {sx, tx, w, 1'b1};
        while (done !== 1'b1 && lat < 9000) begin
            step();
            start = poke && lat == 3;
            lat++;
        end
        `CHK(lat >= (16 << div_code) + w * CPU, 1'b1)
        `CHK(lat <= (16 << div_code) + w * (CPU + 1) + 4, 1'b1)
        `CHK(rx_byte, sx)
        `CHK(slv_rx, options[1] ? e : tx)
        step(2);
        `CHK(busy, 1'b0)
        `CHK(sck_o, options[0])
    endtask
    task automatic drop();
        int n = 0;
        init(3'h2, 3'h0, 1'b0);
        ss_i = 0;
        step();
        `CHK(master_enable_bit, 1'b0)
        {tx_byte, start} = {8'h5A, 1'b1};
        step();
        start = 0;
        while (done !== 1'b1 && n < 4) begin
            step();
            n++;
        end
        `CHK(rx_byte, 8'h00)
    endtask
    initial begin
        {nrst, init_pulse, ss_is_output, start, ss_i} = 5'h01;
        {div_code, options, tx_byte, wait_us, slv_tx} = '0;
        repeat (10) @(posedge clk);
        #1 nrst = 1;
        `CHK(master_enable_bit | busy | done, 1'b0)
        for (int o = 0; o < 8; o++) begin
            init(3'(o % 7), 3'(o), 1'b1);
            xfer(8'hB4 ^ 8'(o), 8'h6D + 8'(o), o == 5 ? 8'h03 : 8'h00, o == 2);
        end
        drop();
        summarize();
    end
endmodule
